// ===== mrl_pkg.sv
// Shared constants of the monitor register bank and its controller
package mrl_pkg;
	localparam int          ADDR_W        = 6;
	localparam int          DATA_W        = 16;
	localparam int          MEAS_W        = 12;
	localparam int          RSV_W         = 4;
	localparam logic [5:0]  ADR_CONFIG    = 6'h00;
	localparam logic [5:0]  ADR_SHUNT     = 6'h01;
	localparam logic [5:0]  ADR_BUS       = 6'h02;
	localparam logic [5:0]  ADR_POWER     = 6'h03;
	localparam logic [5:0]  ADR_CURRENT   = 6'h04;
	localparam logic [5:0]  ADR_SCALE     = 6'h05;
	localparam logic [5:0]  ADR_SELECT    = 6'h06;
	localparam logic [5:0]  ADR_LIMIT     = 6'h07;
	localparam logic [5:0]  ADR_MAKER     = 6'h3E;
	localparam logic [5:0]  ADR_DIE       = 6'h3F;
	localparam logic [15:0] CONFIG_RST    = 16'h0000;
	localparam logic [15:0] SCALE_RST     = 16'h0000;
	localparam logic [15:0] LIMIT_RST     = 16'h0000;
	localparam logic [4:0]  SELECT_RST    = 5'h00;
	localparam int          RANGE_BIT     = 4;
	localparam int          SEL_LO        = 11;
	localparam int          SEL_HI        = 15;
	localparam int          CUR_SHIFT     = 11;
	localparam int          PWR_SHIFT     = 12;
	localparam int          DIE_LO        = 3;
	// Host side register byte addresses
	localparam logic [4:0]  HA_CMD        = 5'h00;
	localparam logic [4:0]  HA_RESULT     = 5'h04;
	localparam logic [4:0]  HA_IRQ_STAT   = 5'h08;
	localparam logic [4:0]  HA_IRQ_CLR    = 5'h0C;
	localparam logic [4:0]  HA_IRQ_EN     = 5'h10;
	localparam int          CMD_ADDR_LO   = 16;
	localparam int          CMD_WR_BIT    = 24;
	localparam int          RES_BUSY_BIT  = 16;
	localparam int          RES_ALERT_BIT = 17;
	localparam int          IRQ_W         = 2;
	localparam int          IRQ_DONE      = 0;
	localparam int          IRQ_ALERT     = 1;
	localparam logic [1:0]  HTRANS_NSEQ   = 2'h2;
endpackage

// ===== mrl_link_if.sv
// Register link between the controller and the monitor register bank
`timescale 1ns/10ps
interface mrl_link_if;
	logic                          req;
	logic                          wr;
	logic [mrl_pkg::ADDR_W-1:0]    addr;
	logic [mrl_pkg::DATA_W-1:0]    wdata;
	logic                          ack;
	logic [mrl_pkg::DATA_W-1:0]    rdata;
	logic                          alert;
	modport dev
	(
		input  req,
		input  wr,
		input  addr,
		input  wdata,
		output ack,
		output rdata,
		output alert
	);
	modport host
	(
		output req,
		output wr,
		output addr,
		output wdata,
		input  ack,
		input  rdata,
		input  alert
	);
endinterface

// ===== mrl_device.sv
// Monitor result, limit and identity register bank
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
module mrl_device #(
	parameter logic [15:0] MAKER_CODE = 16'h4D52, // Arbitrary value
	parameter logic [12:0] DIE_CODE   = 13'h0123  // Arbitrary value
) (
	input  wire logic                       MCLK,
	input  wire logic                       SYS_RST,
	mrl_link_if.dev                         LNK,
	input  wire logic [mrl_pkg::MEAS_W-1:0] SHUNT_CODE,
	input  wire logic [mrl_pkg::MEAS_W-1:0] BUS_CODE,
	input  wire logic                       CONV_DONE,
	output logic                            SHUNT_RANGE,
	output logic                            ALERT
);
	logic        [15:0] config_reg;
	logic        [15:0] scale_reg;
	logic        [15:0] limit_reg;
	logic        [4:0]  select_reg;
	logic signed [11:0] shunt_reg;
	logic        [11:0] bus_reg;
	logic        [15:0] current_reg;
	logic        [15:0] power_reg;
	logic        [1:0]  stage_reg;
	logic               ack_reg;
	logic        [15:0] rdata_reg;
	logic               alert_reg;
	logic               range_reg;

	wire               take;
	wire               wr_hit;
	wire        [15:0] wd;
	wire        [4:0]  sel_in;
	wire        [4:0]  sel_next;
	wire signed [28:0] cur_prod;
	wire        [15:0] current_next;
	wire        [15:0] cur_mag;
	wire        [27:0] pwr_prod;
	wire        [15:0] power_next;
	wire signed [15:0] shunt_full;
	wire        [15:0] bus_full;
	wire signed [15:0] limit_s;
	wire               shunt_over;
	wire               shunt_under;
	wire               bus_over;
	wire               bus_under;
	wire               power_over;
	wire               alert_next;
	wire        [15:0] die_word;
	wire        [15:0] rd_mux;

	// A request is taken once; the ack cycle masks the still-high request
	assign take   = LNK.req & ~ack_reg;
	assign wr_hit = take & LNK.wr;
	assign wd     = LNK.wdata;

	// Only one limit function at a time: highest selected bit wins
	assign sel_in   = wd[mrl_pkg::SEL_HI:mrl_pkg::SEL_LO];
	assign sel_next = sel_in[4] ? 5'h10 :
	                  sel_in[3] ? 5'h08 :
	                  sel_in[2] ? 5'h04 :
	                  sel_in[1] ? 5'h02 :
	                  sel_in[0] ? 5'h01 : 5'h00;

	// Reserved low nibble reads zero
	assign shunt_full = {shunt_reg, 4'h0};
	assign bus_full   = {bus_reg, 4'h0};
	assign limit_s    = limit_reg;

	assign cur_prod     = shunt_reg * $signed({1'b0, scale_reg});
	// Product overflow is not flagged; software keeps the scale in range
	assign current_next = (scale_reg == 16'h0000) ? 16'h0000 :
	                      cur_prod[mrl_pkg::CUR_SHIFT+15:
	                               mrl_pkg::CUR_SHIFT];

	assign cur_mag    = current_reg[15] ? 16'(-current_reg) : current_reg;
	assign pwr_prod   = cur_mag * bus_reg;
	assign power_next = pwr_prod[mrl_pkg::PWR_SHIFT+15:
	                             mrl_pkg::PWR_SHIFT];

	assign shunt_over  = shunt_full > limit_s;
	assign shunt_under = shunt_full < limit_s;
	assign bus_over    = bus_full > limit_reg;
	assign bus_under   = bus_full < limit_reg;
	assign power_over  = power_next > limit_reg;
	assign alert_next  = (select_reg[4] & shunt_over)  |
	                     (select_reg[3] & shunt_under) |
	                     (select_reg[2] & bus_over)    |
	                     (select_reg[1] & bus_under)   |
	                     (select_reg[0] & power_over);

	assign die_word = {DIE_CODE, 3'h0};

	assign rd_mux =
		(LNK.addr == mrl_pkg::ADR_CONFIG)  ? config_reg :
		(LNK.addr == mrl_pkg::ADR_SHUNT)   ? shunt_full :
		(LNK.addr == mrl_pkg::ADR_BUS)     ? bus_full :
		(LNK.addr == mrl_pkg::ADR_POWER)   ? power_reg :
		(LNK.addr == mrl_pkg::ADR_CURRENT) ? current_reg :
		(LNK.addr == mrl_pkg::ADR_SCALE)   ? scale_reg :
		(LNK.addr == mrl_pkg::ADR_SELECT)  ? {select_reg, 11'h000} :
		(LNK.addr == mrl_pkg::ADR_LIMIT)   ? limit_reg :
		(LNK.addr == mrl_pkg::ADR_MAKER)   ? MAKER_CODE :
		(LNK.addr == mrl_pkg::ADR_DIE)     ? die_word :
		16'h0000;

	assign LNK.ack     = ack_reg;
	assign LNK.rdata   = rdata_reg;
	assign LNK.alert   = alert_reg;
	assign ALERT       = alert_reg;
	assign SHUNT_RANGE = range_reg;

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			ack_reg   <= 1'b0;
			rdata_reg <= 16'h0000;
		end
		else
		begin
			ack_reg <= take;
			if (take)
				rdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			config_reg <= mrl_pkg::CONFIG_RST;
			scale_reg  <= mrl_pkg::SCALE_RST;
			limit_reg  <= mrl_pkg::LIMIT_RST;
			select_reg <= mrl_pkg::SELECT_RST;
		end
		else if (wr_hit)
		begin
			// Writes to result and identity words are dropped
			if (LNK.addr == mrl_pkg::ADR_CONFIG)
				config_reg <= wd;
			if (LNK.addr == mrl_pkg::ADR_SCALE)
				scale_reg <= wd;
			if (LNK.addr == mrl_pkg::ADR_LIMIT)
				limit_reg <= wd;
			if (LNK.addr == mrl_pkg::ADR_SELECT)
				select_reg <= sel_next;
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			range_reg <= 1'b0;
		else
			range_reg <= config_reg[mrl_pkg::RANGE_BIT];
	end

	// Results settle in a short pipe so the multipliers stay apart
	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			stage_reg   <= 2'h0;
			shunt_reg   <= 12'h000;
			bus_reg     <= 12'h000;
			current_reg <= 16'h0000;
			power_reg   <= 16'h0000;
			alert_reg   <= 1'b0;
		end
		else
		begin
			stage_reg <= {stage_reg[0], CONV_DONE};
			if (CONV_DONE)
			begin
				shunt_reg <= SHUNT_CODE;
				bus_reg   <= BUS_CODE;
			end
			if (stage_reg[0])
				current_reg <= current_next;
			if (stage_reg[1])
			begin
				power_reg <= power_next;
				alert_reg <= alert_next;
			end
		end
	end
endmodule

// ===== mrl_host.sv
// Link controller for the monitor bank, driven over AHB-Lite
`timescale 1ns/10ps
module mrl_host
(
	input  wire logic        MCLK,
	input  wire logic        SYS_RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	output logic             IRQ,
	mrl_link_if.host         LNK
);
	logic [4:0]  waddr_reg;
	logic        wpend_reg;
	logic [31:0] hrdata_reg;
	logic        req_reg;
	logic        wr_reg;
	logic [5:0]  addr_reg;
	logic [15:0] wdata_reg;
	logic [15:0] result_reg;
	logic        alert_seen_reg;
	logic [1:0]  irq_stat_reg;
	logic [1:0]  irq_en_reg;
	logic        irq_reg;

	wire        addr_ph;
	wire [4:0]  a_lo;
	wire        w_cmd;
	wire        w_clr;
	wire        w_en;
	wire        start;
	wire        done;
	wire        alert_rise;
	wire [1:0]  ev;
	wire [1:0]  clr;
	wire [1:0]  stat_next;
	wire [31:0] rd_mux;

	// HSIZE is ignored: only whole-word accesses are supported
	assign addr_ph = HSEL & HREADY & (HTRANS == mrl_pkg::HTRANS_NSEQ);
	assign a_lo    = HADDR[4:0];
	assign w_cmd   = wpend_reg & (waddr_reg == mrl_pkg::HA_CMD);
	assign w_clr   = wpend_reg & (waddr_reg == mrl_pkg::HA_IRQ_CLR);
	assign w_en    = wpend_reg & (waddr_reg == mrl_pkg::HA_IRQ_EN);
	// A command written while busy is dropped
	assign start   = w_cmd & ~req_reg;
	assign done    = req_reg & LNK.ack;
	assign alert_rise = LNK.alert & ~alert_seen_reg;
	assign ev      = {alert_rise, done};
	assign clr     = w_clr ? HWDATA[mrl_pkg::IRQ_W-1:0] : 2'h0;
	// Set wins over a clear in the same cycle
	assign stat_next = (irq_stat_reg & ~clr) | ev;

	assign rd_mux =
		(a_lo == mrl_pkg::HA_CMD) ?
			{7'h00, wr_reg, 2'h0, addr_reg, wdata_reg} :
		(a_lo == mrl_pkg::HA_RESULT) ?
			{14'h0000, LNK.alert, req_reg, result_reg} :
		(a_lo == mrl_pkg::HA_IRQ_STAT) ? {30'h00000000, irq_stat_reg} :
		(a_lo == mrl_pkg::HA_IRQ_EN)   ? {30'h00000000, irq_en_reg} :
		32'h00000000;

	assign HRDATA    = hrdata_reg;
	assign LNK.req   = req_reg;
	assign LNK.wr    = wr_reg;
	assign LNK.addr  = addr_reg;
	assign LNK.wdata = wdata_reg;
	assign IRQ       = irq_reg;

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			wpend_reg  <= 1'b0;
			waddr_reg  <= 5'h00;
			hrdata_reg <= 32'h00000000;
			HREADYOUT  <= 1'b1;
			HRESP      <= 1'b0;
		end
		else
		begin
			wpend_reg <= addr_ph & HWRITE;
			if (addr_ph)
				waddr_reg <= a_lo;
			if (addr_ph & ~HWRITE)
				hrdata_reg <= rd_mux;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			req_reg    <= 1'b0;
			wr_reg     <= 1'b0;
			addr_reg   <= 6'h00;
			wdata_reg  <= 16'h0000;
			result_reg <= 16'h0000;
		end
		else if (start)
		begin
			req_reg   <= 1'b1;
			wr_reg    <= HWDATA[mrl_pkg::CMD_WR_BIT];
			addr_reg  <= HWDATA[mrl_pkg::CMD_ADDR_LO+5:mrl_pkg::CMD_ADDR_LO];
			// Threshold and scale words pass untouched; format is software's
			wdata_reg <= HWDATA[15:0];
		end
		else if (done)
		begin
			req_reg    <= 1'b0;
			result_reg <= LNK.rdata;
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			alert_seen_reg <= 1'b0;
			irq_stat_reg   <= 2'h0;
			irq_en_reg     <= 2'h0;
			irq_reg        <= 1'b0;
		end
		else
		begin
			alert_seen_reg <= LNK.alert;
			irq_stat_reg   <= stat_next;
			if (w_en)
				irq_en_reg <= HWDATA[mrl_pkg::IRQ_W-1:0];
			irq_reg <= |(stat_next & (w_en ?
				HWDATA[mrl_pkg::IRQ_W-1:0] : irq_en_reg));
		end
	end
endmodule

// ===== mrl_sva.sv
// Link protocol and register read checks
`timescale 1ns/10ps
module mrl_sva #(
	parameter logic [15:0] MAKER_CODE = 16'h4D52, // Arbitrary value
	parameter logic [12:0] DIE_CODE   = 13'h0123  // Arbitrary value
) (
	input wire logic        MCLK,
	input wire logic        SYS_RST,
	input wire logic        req,
	input wire logic        wr,
	input wire logic [5:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        ack,
	input wire logic [15:0] rdata
);
	logic [15:0] lim_reg;
	wire         rd_ack = ack && !wr;
	default clocking @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	sequence taken_s;
		req && !ack;
	endsequence
	sequence answer_s;
		ack ##1 !ack;
	endsequence
	// Shadow of the threshold, so read-back is judged by the link alone
	always_ff @(posedge MCLK or posedge SYS_RST)
		if (SYS_RST)
			lim_reg <= 16'h0000;
		else if (ack && wr && addr == mrl_pkg::ADR_LIMIT)
			lim_reg <= wdata;
	take_ack_a: assert property (taken_s |=> answer_s)
		else $error("link ack not one pulse after request");
	ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
		else $error("link ack without request");
	req_drop_a: assert property (ack |=> !req)
		else $error("link request held past ack");
	req_hold_a: assert property (taken_s |=> $stable({wr, addr, wdata}))
		else $error("link request changed before ack");
	rdata_hold_a: assert property (!ack |-> $stable(rdata))
		else $error("link read data moved without ack");
	maker_read_a: assert property (
		rd_ack && addr == mrl_pkg::ADR_MAKER |-> rdata == MAKER_CODE)
		else $error("maker code wrong");
	die_read_a: assert property (
		rd_ack && addr == mrl_pkg::ADR_DIE |-> rdata == {DIE_CODE, 3'h0})
		else $error("die code wrong");
	rsv_bits_a: assert property (
		rd_ack && (addr == mrl_pkg::ADR_SHUNT ||
		addr == mrl_pkg::ADR_BUS) |-> rdata[3:0] == 4'h0)
		else $error("reserved result bits set");
	limit_read_a: assert property (
		rd_ack && addr == mrl_pkg::ADR_LIMIT |-> rdata == lim_reg)
		else $error("threshold read back wrong");
endmodule

// ===== mrl_bench.sv
// Self-checking bench of controller and register bank
`timescale 1ns/10ps
module mrl_bench;
	localparam logic [15:0] MK = 16'h4D52; // Arbitrary value
	localparam logic [12:0] DI = 13'h0123; // Arbitrary value
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        irq;
	logic [11:0] shunt_code = 12'h0;
	logic [11:0] bus_code = 12'h0;
	logic        conv_done = 1'b0;
	logic        shunt_range;
	logic        alert;
	logic [31:0] seed = 32'h412FE8E3;
	logic [31:0] rd;
	logic [15:0] v;
	logic [15:0] k;
	logic [15:0] c;
	logic [11:0] s;
	logic [11:0] b;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc = 0;
	mrl_link_if lnk ();
	mrl_host mrl_host_i (.MCLK(mclk), .SYS_RST(sys_rst), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
		.HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq), .LNK(lnk.host));
	mrl_device #(.MAKER_CODE(MK), .DIE_CODE(DI)) mrl_device_i (.MCLK(mclk),
		.SYS_RST(sys_rst), .LNK(lnk.dev), .SHUNT_CODE(shunt_code),
		.BUS_CODE(bus_code), .CONV_DONE(conv_done),
		.SHUNT_RANGE(shunt_range), .ALERT(alert));
	mrl_sva #(.MAKER_CODE(MK), .DIE_CODE(DI)) mrl_sva_i (.MCLK(mclk),
		.SYS_RST(sys_rst), .req(lnk.req), .wr(lnk.wr), .addr(lnk.addr),
		.wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata));
	always #2.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			error_cnt++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic logic [31:0] rnd(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [15:0] ecur(logic [11:0] sh, logic [15:0] sc);
		logic signed [28:0] p;
		p = $signed(sh) * $signed({1'b0, sc});
		return (sc == 16'h0) ? 16'h0 : p[26:11];
	endfunction
	function automatic logic [15:0] epwr(logic [15:0] cu, logic [11:0] bu);
		logic [15:0] m;
		logic [27:0] q;
		m = cu[15] ? -cu : cu;
		q = m * bu;
		return q[27:12];
	endfunction
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// The master waits on hready rather than assuming zero wait states
	task automatic ahb(logic w, logic [4:0] a, logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= mrl_pkg::HTRANS_NSEQ;
		hwrite <= w;
		haddr <= {27'h0, a};
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
		chk({30'h0, hreadyout, hresp}, 32'h2);
	endtask
	task automatic lop(logic w, logic [5:0] a, logic [15:0] d);
		ahb(1'b1, mrl_pkg::HA_CMD, {7'h0, w, 2'h0, a, d});
		ahb(1'b0, mrl_pkg::HA_RESULT, 32'h0);
		while (rd[mrl_pkg::RES_BUSY_BIT] !== 1'b0)
			ahb(1'b0, mrl_pkg::HA_RESULT, 32'h0);
	endtask
	task automatic conv(logic [11:0] sh, logic [11:0] bu);
		@(posedge mclk);
		shunt_code <= sh;
		bus_code <= bu;
		conv_done <= 1'b1;
		@(posedge mclk);
		conv_done <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	task automatic alm(logic [15:0] sl, logic [15:0] lm, logic [11:0] sh,
		logic [11:0] bu, logic ex);
		lop(1'b1, mrl_pkg::ADR_SELECT, sl);
		lop(1'b1, mrl_pkg::ADR_LIMIT, lm);
		conv(sh, bu);
		chk(alert, ex);
	endtask
	initial
	begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		lop(1'b0, mrl_pkg::ADR_LIMIT, 16'h0);
		chk(rd[15:0], 16'h0000);
		lop(1'b1, mrl_pkg::ADR_MAKER, 16'h0000);
		lop(1'b0, mrl_pkg::ADR_MAKER, 16'h0);
		chk(rd[15:0], MK);
		lop(1'b0, mrl_pkg::ADR_DIE, 16'h0);
		chk(rd[15:0], {DI, 3'h0});
		lop(1'b0, 6'h20, 16'h0);
		chk(rd[15:0], 16'h0000);
		for (int i = 0; i < 3; i++)
		begin
			seed = rnd(seed);
			v = (i == 0) ? 16'hFFFF : seed[15:0];
			lop(1'b1, mrl_pkg::ADR_LIMIT, v);
			lop(1'b0, mrl_pkg::ADR_LIMIT, 16'h0);
			chk(rd[15:0], v);
		end
		for (int i = 0; i < 6; i++)
		begin
			seed = rnd(seed);
			s = (i == 1) ? 12'h800 : seed[11:0];
			b = seed[23:12];
			k = (i == 0) ? 16'h0 : {1'b0, seed[30:16]};
			lop(1'b1, mrl_pkg::ADR_SCALE, k);
			conv(s, b);
			lop(1'b0, mrl_pkg::ADR_SHUNT, 16'h0);
			chk(rd[15:0], {s, 4'h0});
			lop(1'b0, mrl_pkg::ADR_BUS, 16'h0);
			chk(rd[15:0], {b, 4'h0});
			c = ecur(s, k);
			lop(1'b0, mrl_pkg::ADR_CURRENT, 16'h0);
			chk(rd[15:0], c);
			lop(1'b0, mrl_pkg::ADR_POWER, 16'h0);
			chk(rd[15:0], epwr(c, b));
		end
		lop(1'b1, mrl_pkg::ADR_CONFIG, 16'h0010);
		chk(shunt_range, 1'b1);
		// Narrow range: a quarter of the wide-range scale 1000h
		lop(1'b1, mrl_pkg::ADR_SCALE, 16'h0400);
		conv(12'h7FF, 12'h100);
		lop(1'b0, mrl_pkg::ADR_CURRENT, 16'h0);
		chk(rd[15:0], ecur(12'h7FF, 16'h0400));
		lop(1'b1, mrl_pkg::ADR_CONFIG, 16'h0000);
		chk(shunt_range, 1'b0);
		lop(1'b1, mrl_pkg::ADR_SELECT, 16'h1000);
		lop(1'b1, mrl_pkg::ADR_LIMIT, 16'h2000);
		conv(12'h100, 12'h100);
		chk(alert, 1'b1);
		chk(irq, 1'b0);
		ahb(1'b0, mrl_pkg::HA_IRQ_STAT, 32'h0);
		chk(rd[1:0], 2'h3);
		ahb(1'b1, mrl_pkg::HA_IRQ_EN, 32'h2);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b1);
		ahb(1'b1, mrl_pkg::HA_IRQ_CLR, 32'h3);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0);
		conv(12'h100, 12'h300);
		chk(alert, 1'b0);
		lop(1'b1, mrl_pkg::ADR_SELECT, 16'hF800);
		lop(1'b0, mrl_pkg::ADR_SELECT, 16'h0);
		chk(rd[15:0], 16'h8000);
		lop(1'b1, mrl_pkg::ADR_SCALE, 16'h0800);
		// 0100h lies above F000h only as two's complement
		alm(16'h8000, 16'hF000, 12'h010, 12'h000, 1'b1);
		ahb(1'b0, mrl_pkg::HA_RESULT, 32'h0);
		chk(rd[17:16], 2'h2);
		chk(irq, 1'b1);
		ahb(1'b1, mrl_pkg::HA_IRQ_CLR, 32'h2);
		repeat (2) @(posedge mclk);
		chk(irq, 1'b0);
		alm(16'h8000, 16'hF000, 12'hE00, 12'h000, 1'b0);
		alm(16'h4000, 16'hF000, 12'hE00, 12'h000, 1'b1);
		alm(16'h4000, 16'hF000, 12'h010, 12'h000, 1'b0);
		alm(16'h2000, 16'h2000, 12'h000, 12'h300, 1'b1);
		alm(16'h2000, 16'h2000, 12'h000, 12'h200, 1'b0);
		alm(16'h1000, 16'h2000, 12'h000, 12'h200, 1'b0);
		alm(16'h0800, 16'h007F, 12'h100, 12'h800, 1'b1);
		alm(16'h0800, 16'h0080, 12'h100, 12'h800, 1'b0);
		ahb(1'b0, mrl_pkg::HA_CMD, 32'h0);
		chk(rd, {7'h0, 1'b1, 2'h0, mrl_pkg::ADR_LIMIT, 16'h0080});
		ahb(1'b1, mrl_pkg::HA_IRQ_CLR, 32'h3);
		ahb(1'b1, mrl_pkg::HA_IRQ_EN, 32'h1);
		lop(1'b0, mrl_pkg::ADR_LIMIT, 16'h0);
		chk(rd[15:0], 16'h0080);
		ahb(1'b0, mrl_pkg::HA_IRQ_STAT, 32'h0);
		chk(rd[1:0], 2'h1);
		chk(irq, 1'b1);
		end_sim();
	end
endmodule
